// ===== inc/medt_pkg.sv
// shared constants and types of the tail-ops execution datapath
package medt_pkg;

   // ----------------------------------------------------------------
   // register map (axi4-lite byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_ACC_OFS   = 8'h00;
   localparam logic [7:0] REG_FLAGS_OFS = 8'h04;
   localparam logic [7:0] REG_LPTR_OFS  = 8'h08;
   localparam logic [7:0] REG_LHIGH_OFS = 8'h0C;
   localparam logic [7:0] REG_SKIPS_OFS = 8'h10;

   // ----------------------------------------------------------------
   // flag bit positions and reset values
   // ----------------------------------------------------------------
   localparam int         FLG_C      = 0;
   localparam int         FLG_AC     = 1;
   localparam int         FLG_Z      = 2;
   localparam int         FLG_OV     = 3;
   localparam logic [7:0] ACC_RST    = 8'h00;
   localparam logic [3:0] FLAGS_RST  = 4'h0;
   localparam logic [7:0] LPTR_RST   = 8'h00;
   localparam logic [7:0] SKIPS_RST  = 8'h00;
   localparam logic [7:0] FILL_VALUE = 8'hFF;

   // ----------------------------------------------------------------
   // bus answers and program memory layout
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int         PAGE_W      = 4;
   localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hF;

   // ----------------------------------------------------------------
   // operations, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [17:0] {
      OP_FILL  = 18'h00001, OP_BSET  = 18'h00002, OP_INCS  = 18'h00004,
      OP_INCAS = 18'h00008, OP_BTNZ  = 18'h00010, OP_BTZ   = 18'h00020,
      OP_SUBA  = 18'h00040, OP_MINUS_TO_MEM  = 18'h00080, OP_SUBI  = 18'h00100,
      OP_SWAP  = 18'h00200, OP_NIBBLE_EXCHANGE_TO_ACC = 18'h00400, OP_TZ    = 18'h00800,
      OP_TZA   = 18'h01000, OP_TRDC  = 18'h02000, OP_TRDL  = 18'h04000,
      OP_XORA  = 18'h08000, OP_BITWISE_DIFF_TO_MEM  = 18'h10000, OP_XORI  = 18'h20000
   } medt_op_t;

   // one decoded instruction as handed over by the decoder
   typedef struct packed {
      medt_op_t          op;
      logic [7:0]        addr;
      logic [2:0]        bit_sel;
      logic [7:0]        imm;
      logic [PAGE_W-1:0] page;
   } medt_instr_t;

endpackage : medt_pkg

// ===== tb/medt_exec_chk.sv
// concurrent checks on the ports of the execution datapath
`timescale 1ns/1ps

module medt_exec_chk
   import medt_pkg::*;
#(
   parameter int ROM_W = 16
) (
   input wire logic             clk,
   input wire logic             rst_n,
   input wire logic             instr_valid,
   input wire medt_instr_t      instr,
   input wire logic [7:0]       mem_raddr,
   input wire logic [7:0]       mem_rdata,
   input wire logic             mem_we,
   input wire logic [7:0]       mem_waddr,
   input wire logic [7:0]       mem_wdata,
   input wire logic [ROM_W-1:0] rom_rdata,
   input wire logic [7:0]       acc,
   input wire logic [3:0]       flags,
   input wire logic [ROM_W-9:0] lookup_high_latch,
   input wire logic             skip,
   input wire logic             done
);
   medt_instr_t      i1_q;
   medt_instr_t      i2_q;
   logic [7:0]       m_q;
   logic             byp_q;
   logic [ROM_W-1:0] r_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // operands seen by the instruction in its execute cycle
   always_ff @(posedge clk) begin
      i1_q  <= instr;
      i2_q  <= i1_q;
      m_q   <= mem_rdata;
      byp_q <= mem_we && mem_waddr == mem_raddr;  // byte still in flight
      r_q   <= rom_rdata;
   end

   a_fill_all_ones:
   assert property (done && i2_q.op == OP_FILL |-> mem_we && mem_wdata == FILL_VALUE && flags == $past(flags))
      else $error("fill result wrong");
   a_bit_raise_only:
   assert property (done && i2_q.op == OP_BSET && !byp_q
      |-> mem_wdata == (m_q | (8'h01 << i2_q.bit_sel)) && flags == $past(flags)) else $error("bit raise wrong");
   a_inc_wrap_skip:
   assert property (done && i2_q.op == OP_INCS && !byp_q
      |-> mem_we && mem_wdata == 8'(m_q + 8'h01) && skip == (m_q == 8'hFF)) else $error("increment skip wrong");
   a_skip_annuls_next:
   assert property (skip |=> !done && !mem_we) else $error("slot after skip not dropped");
   a_done_one_cycle:
   assert property (done == ($past(instr_valid, 2) && !$past(skip))) else $error("done cadence wrong");
   a_bit_test_skip:
   assert property (done && (i2_q.op == OP_BTNZ || i2_q.op == OP_BTZ) && !byp_q
      |-> skip == (m_q[i2_q.bit_sel] == (i2_q.op == OP_BTNZ)) && !mem_we) else $error("bit test wrong");
   a_sub_into_acc:
   assert property (done && i2_q.op == OP_SUBA && !byp_q
      |-> acc == 8'($past(acc) - m_q) && flags[FLG_Z] == (acc == 8'h00)) else $error("subtract wrong");
   a_table_read_split:
   assert property (done && (i2_q.op == OP_TRDC || i2_q.op == OP_TRDL)
      |-> mem_we && mem_wdata == r_q[7:0] && lookup_high_latch == r_q[ROM_W-1:8]) else $error("table read wrong");
   a_xor_to_mem:
   assert property (done && i2_q.op == OP_BITWISE_DIFF_TO_MEM && !byp_q
      |-> mem_wdata == ($past(acc) ^ m_q) && flags[FLG_Z] == (mem_wdata == 8'h00)) else $error("xor to byte wrong");
endmodule : medt_exec_chk

bind medt_exec medt_exec_chk #(.ROM_W(ROM_W)) u_chk (
   .clk, .rst_n, .instr_valid, .instr, .mem_raddr, .mem_rdata, .mem_we, .mem_waddr, .mem_wdata,
   .rom_rdata, .acc, .flags, .lookup_high_latch, .skip, .done
);

// ===== tb/tb_medt_exec.sv
// self-checking bench of the execution datapath and its register bus
`timescale 1ns/1ps

module tb_medt_exec
   import medt_pkg::*;
;
   logic              clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0;
   medt_instr_t       instr = '0;
   logic              mem_we, skip, done;
   logic [7:0]        mem_raddr, mem_rdata, mem_waddr, mem_wdata, acc, lookup_high_latch;
   logic [PAGE_W+7:0] rom_addr;
   logic [15:0]       rom_rdata;
   logic [3:0]        flags;
   logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]       s_axi_wdata = 32'h0;
   logic [3:0]        s_axi_wstrb = 4'hF;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0]       s_axi_rdata;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic [7:0]        mem [256];
   logic [7:0]        ea = ACC_RST, eh = 8'h00, wd, lptr = LPTR_RST, nsk = SKIPS_RST;
   logic [3:0]        ef = FLAGS_RST;
   logic              we, sk;
   int                n_errors = 0, samples_checked = 0, cyc = 0;

   medt_exec DUT (
      .clk, .rst_n, .instr_valid, .instr, .mem_raddr, .mem_rdata, .mem_we, .mem_waddr, .mem_wdata,
      .rom_addr, .rom_rdata, .acc, .flags, .lookup_high_latch, .skip, .done,
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
      .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp
   );

   // clock, bench data memory and program memory
   always #10 clk = ~clk;
   assign mem_rdata = mem[mem_raddr];
   assign rom_rdata = {4'hA, rom_addr} ^ 16'h003C;

   // memory write-back and hang limit
   always @(posedge clk) begin
      if (mem_we) mem[mem_waddr] <= mem_wdata;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   // expected effect of one instruction on acc, flags, latch and memory
   task automatic model(input medt_op_t o, input logic [7:0] m, input logic [2:0] b, input logic [7:0] x,
                        input logic [15:0] w);
      logic [7:0] s;
      logic [8:0] c9;
      logic [4:0] c5;
      we = 1'b0;
      sk = 1'b0;
      wd = 8'h00;
      s = (o == OP_SUBI) ? x : m;
      c9 = {1'b0, ea} + {1'b0, ~s} + 9'h001;
      c5 = {1'b0, ea[3:0]} + {1'b0, ~s[3:0]} + 5'h01;
      case (o)
         OP_FILL: {we, wd} = {1'b1, FILL_VALUE};
         OP_BSET: {we, wd} = {1'b1, m | (8'h01 << b)};
         OP_INCS: {we, wd, sk} = {1'b1, 8'(m + 8'h01), m == 8'hFF};
         OP_INCAS: {ea, sk} = {8'(m + 8'h01), m == 8'hFF};
         OP_BTNZ: sk = m[b];
         OP_BTZ: sk = !m[b];
         OP_SUBA, OP_SUBI, OP_MINUS_TO_MEM: begin
            ef = {(ea[7] ^ s[7]) & (ea[7] ^ c9[7]), c9[7:0] == 8'h00, c5[4], c9[8]};
            if (o == OP_MINUS_TO_MEM) {we, wd} = {1'b1, c9[7:0]};
            else ea = c9[7:0];
         end
         OP_SWAP: {we, wd} = {1'b1, m[3:0], m[7:4]};
         OP_NIBBLE_EXCHANGE_TO_ACC: ea = {m[3:0], m[7:4]};
         OP_TZ: sk = (m == 8'h00);
         OP_TZA: {ea, sk} = {m, m == 8'h00};
         OP_TRDC, OP_TRDL: {we, wd, eh} = {1'b1, w[7:0], w[15:8]};
         default: begin
            s = ea ^ ((o == OP_XORI) ? x : m);
            ef[FLG_Z] = (s == 8'h00);
            if (o == OP_BITWISE_DIFF_TO_MEM) {we, wd} = {1'b1, s};
            else ea = s;
         end
      endcase
   endtask : model

   // one instruction, followed at once by a fill of byte F0 that a taken skip must drop
   task automatic ex(input medt_op_t o, input logic [7:0] a, input logic [2:0] b, input logic [7:0] x);
      logic [7:0] m;
      m = mem[a];
      model(o, m, b, x, {4'hA, (o == OP_TRDL) ? LAST_PAGE : 4'h3, lptr} ^ 16'h003C);
      nsk = nsk + {7'h00, sk};
      mem[8'hF0] <= 8'h00;
      instr_valid <= 1'b1;
      instr <= '{op: o, addr: a, bit_sel: b, imm: x, page: 4'h3};
      @(posedge clk);
      instr <= '{op: OP_FILL, addr: 8'hF0, bit_sel: b, imm: x, page: 4'h3};
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      check(done, 1'b1);
      check(skip, sk);
      check(acc, ea);
      check(flags, ef);
      check(lookup_high_latch, eh);
      check(mem_we, we);
      @(posedge clk);
      #1;
      check(done, !sk);
      check(mem[a], we ? wd : m);
      @(posedge clk);
      #1;
      check(mem[8'hF0], sk ? 8'h00 : FILL_VALUE);
      @(posedge clk);
   endtask : ex

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check(s_axi_bresp, er);
      @(posedge clk);
   endtask : axw

   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, ed);
      check(s_axi_rresp, er);
      @(posedge clk);
   endtask : axr

   // main sequence
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 5; i++) axr(8'(i * 4), 32'h0, RESP_OKAY);
      axr(8'h14, 32'h0, RESP_SLVERR);
      axw(8'h14, 32'hFF, RESP_SLVERR);
      axw(REG_LHIGH_OFS, 32'hFF, RESP_OKAY);
      axr(REG_LHIGH_OFS, 32'h0, RESP_OKAY);
      axw(REG_FLAGS_OFS, 32'hF, RESP_OKAY);
      axw(REG_ACC_OFS, 32'h5A, RESP_OKAY);
      axr(REG_ACC_OFS, 32'h5A, RESP_OKAY);
      {ef, ea} = {4'hF, 8'h5A};
      $display("test registers done");
      ex(OP_FILL, 8'h01, 3'h0, 8'h00);
      ex(OP_BSET, 8'h02, 3'h7, 8'h00);
      ex(OP_BSET, 8'h03, 3'h0, 8'h00);
      ex(OP_INCS, 8'hFF, 3'h0, 8'h00);
      ex(OP_INCS, 8'h10, 3'h0, 8'h00);
      ex(OP_INCAS, 8'h01, 3'h0, 8'h00);
      ex(OP_INCAS, 8'h20, 3'h0, 8'h00);
      ex(OP_BTNZ, 8'h80, 3'h7, 8'h00);
      ex(OP_BTNZ, 8'h80, 3'h6, 8'h00);
      ex(OP_BTZ, 8'h80, 3'h0, 8'h00);
      ex(OP_BTZ, 8'h01, 3'h0, 8'h00);
      ex(OP_TZ, 8'h00, 3'h0, 8'h00);
      ex(OP_TZ, 8'h05, 3'h0, 8'h00);
      ex(OP_TZA, 8'h00, 3'h0, 8'h00);
      ex(OP_TZA, 8'h44, 3'h0, 8'h00);
      ex(OP_XORA, 8'h44, 3'h0, 8'h00);
      ex(OP_BITWISE_DIFF_TO_MEM, 8'h56, 3'h0, 8'h00);
      ex(OP_XORI, 8'h00, 3'h0, 8'h3C);
      ex(OP_SUBA, 8'h3C, 3'h0, 8'h00);
      ex(OP_SUBA, 8'h45, 3'h0, 8'h00);
      ex(OP_SUBI, 8'h00, 3'h0, 8'h7F);
      ex(OP_MINUS_TO_MEM, 8'h30, 3'h0, 8'h00);
      ex(OP_SWAP, 8'h12, 3'h0, 8'h00);
      ex(OP_NIBBLE_EXCHANGE_TO_ACC, 8'h34, 3'h0, 8'h00);
      $display("test operations done");
      axw(REG_LPTR_OFS, 32'h9C, RESP_OKAY);
      lptr = 8'h9C;
      ex(OP_TRDC, 8'h60, 3'h0, 8'h00);
      ex(OP_TRDL, 8'h61, 3'h0, 8'h00);
      axr(REG_LHIGH_OFS, {24'h0, eh}, RESP_OKAY);
      axr(REG_SKIPS_OFS, {24'h0, nsk}, RESP_OKAY);
      $display("test table reads done");
      summarize();
   end
endmodule : tb_medt_exec

// ===== verilog/medt_exec.sv
// execution datapath for the skip, subtract, swap, table-read and xor group
// Functional notes
// - fill writes FFH to the addressed byte, flags untouched.
// - bit raise sets only the chosen bit; other bits and flags kept.
// - inc_skip_on_wrap writes byte plus one back, skips when sum is zero.
// - inc_to_acc_skip loads byte plus one into acc, memory kept, skip on zero.
// - taken skip discards fetched next instruction, one dummy cycle, two cycles total.
// - bit tests skip on bit one or bit zero; no memory or flag change.
// - acc minus byte via inverse plus one into acc, updates OV Z AC C.
// - minus_to_mem writes acc minus byte back to memory, updates arithmetic flags.
// - acc minus immediate into acc, updates OV Z AC C.
// - nibble_exchange swaps nibbles in place, flags untouched.
// - nibble_exchange_to_acc puts swapped byte in acc, memory unchanged.
// - zero_test_skip skips when whole byte is zero, changes nothing.
// - copy_zero_test_skip copies byte to acc and skips when it is zero.
// - rom_fetch_cur_page reads current page word at pointer; low to memory, high latched.
// - rom_fetch_last_page does the same from the last program page.
// - xor acc with byte into acc, updates zero flag.
// - bitwise_diff_to_mem writes acc xor byte to memory, updates zero flag.
// - xor acc with immediate into acc, updates zero flag.
`timescale 1ns/1ps

module medt_exec
   import medt_pkg::*;
#(
   parameter int ROM_W = 16
) (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    instr_valid,
   input  wire medt_instr_t             instr,
   output logic [7:0]                   mem_raddr,
   input  wire logic [7:0]              mem_rdata,
   output logic                         mem_we,
   output logic [7:0]                   mem_waddr,
   output logic [7:0]                   mem_wdata,
   output logic [PAGE_W+7:0]            rom_addr,
   input  wire logic [ROM_W-1:0]        rom_rdata,
   output logic [7:0]                   acc,
   output logic [3:0]                   flags,
   output logic [ROM_W-9:0]             lookup_high_latch,
   output logic                         skip,
   output logic                         done,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   output logic [1:0]                   s_axi_bresp,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   input  wire logic [7:0]              s_axi_araddr,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp
);

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // a + ~b + 1, returns {ov, ac, c, result}
   function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, ~b} + 9'h001;
      h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      sub8 = {(a[7] ^ b[7]) & (a[7] ^ s[7]), h[4], s[8], s[7:0]};
   endfunction : sub8

   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == 8'h00);
   endfunction : is_zero

   function automatic logic [3:0] arith_flags(input logic [10:0] r, input logic [3:0] f);
      logic [3:0] n;
      n         = f;
      n[FLG_OV] = r[10];
      n[FLG_AC] = r[9];
      n[FLG_C]  = r[8];
      n[FLG_Z]  = is_zero(r[7:0]);
      arith_flags = n;
   endfunction : arith_flags

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   medt_instr_t       ex_q;
   logic              ex_valid_q, skip_q, done_q, mem_we_q;
   logic [7:0]        acc_q, lptr_q, skips_q, mem_waddr_q, mem_wdata_q;
   logic [3:0]        flags_q;
   logic [ROM_W-9:0]  lhigh_q;
   logic [PAGE_W+7:0] rom_addr_q;

   // ----------------------------------------------------------------
   // execute stage, combinational
   // ----------------------------------------------------------------
   logic [7:0]  m, inc, x_acc, x_imm, wd, acc_n;
   logic [10:0] r_mem, r_imm;
   logic [3:0]  flags_n;
   logic        wr_mem, wr_acc, wr_lh, taken;

   // bypass the write still in flight to the same byte
   assign m     = (mem_we_q && mem_waddr_q == ex_q.addr) ? mem_wdata_q : mem_rdata;
   assign inc   = m + 8'h01;
   assign x_acc = acc_q ^ m;
   assign x_imm = acc_q ^ ex_q.imm;
   assign r_mem = sub8(acc_q, m);
   assign r_imm = sub8(acc_q, ex_q.imm);

   // operation decode; annulled slot does nothing
   always_comb begin
      wr_mem  = 1'b0;
      wd      = m;
      wr_acc  = 1'b0;
      acc_n   = acc_q;
      flags_n = flags_q;
      wr_lh   = 1'b0;
      taken   = 1'b0;
      if (ex_valid_q) begin
         case (ex_q.op)
            OP_FILL: begin
               wr_mem = 1'b1;
               wd     = FILL_VALUE;
            end
            OP_BSET: begin
               wr_mem = 1'b1;
               wd     = m | (8'h01 << ex_q.bit_sel);
            end
            OP_INCS: begin
               wr_mem = 1'b1;
               wd     = inc;
               taken  = is_zero(inc);
            end
            OP_INCAS: begin
               wr_acc = 1'b1;
               acc_n  = inc;
               taken  = is_zero(inc);
            end
            OP_BTNZ: taken = m[ex_q.bit_sel];
            OP_BTZ:  taken = ~m[ex_q.bit_sel];
            OP_SUBA: begin
               wr_acc  = 1'b1;
               acc_n   = r_mem[7:0];
               flags_n = arith_flags(r_mem, flags_q);
            end
            OP_MINUS_TO_MEM: begin
               wr_mem  = 1'b1;
               wd      = r_mem[7:0];
               flags_n = arith_flags(r_mem, flags_q);
            end
            OP_SUBI: begin
               wr_acc  = 1'b1;
               acc_n   = r_imm[7:0];
               flags_n = arith_flags(r_imm, flags_q);
            end
            OP_SWAP: begin
               wr_mem = 1'b1;
               wd     = {m[3:0], m[7:4]};
            end
            OP_NIBBLE_EXCHANGE_TO_ACC: begin
               wr_acc = 1'b1;
               acc_n  = {m[3:0], m[7:4]};
            end
            OP_TZ: taken = is_zero(m);
            OP_TZA: begin
               wr_acc = 1'b1;
               acc_n  = m;
               taken  = is_zero(m);
            end
            OP_TRDC, OP_TRDL: begin
               wr_mem = 1'b1;
               wd     = rom_rdata[7:0];
               wr_lh  = 1'b1;
            end
            OP_XORA: begin
               wr_acc         = 1'b1;
               acc_n          = x_acc;
               flags_n[FLG_Z] = is_zero(x_acc);
            end
            OP_BITWISE_DIFF_TO_MEM: begin
               wr_mem         = 1'b1;
               wd             = x_acc;
               flags_n[FLG_Z] = is_zero(x_acc);
            end
            OP_XORI: begin
               wr_acc         = 1'b1;
               acc_n          = x_imm;
               flags_n[FLG_Z] = is_zero(x_imm);
            end
            default: begin
               wr_mem = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite slave handshakes
   // ----------------------------------------------------------------
   logic        aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic        aw_hs, w_hs, wr_go, ar_hs, reg_wr, wr_mapped, rd_mapped;
   logic        aw_have_d, w_have_d, bvalid_d, rvalid_d;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q, rdata_q, rd_word;
   logic [3:0]  wstrb_q;
   logic [1:0]  bresp_q, rresp_q;

   assign aw_hs     = s_axi_awvalid & awready_q;
   assign w_hs      = s_axi_wvalid & wready_q;
   assign wr_go     = aw_have_q & w_have_q & ~bvalid_q;
   assign ar_hs     = s_axi_arvalid & arready_q;
   assign reg_wr    = wr_go & wstrb_q[0];
   assign aw_have_d = (aw_have_q | aw_hs) & ~wr_go;
   assign w_have_d  = (w_have_q | w_hs) & ~wr_go;
   assign bvalid_d  = wr_go | (bvalid_q & ~s_axi_bready);
   assign rvalid_d  = ar_hs | (rvalid_q & ~s_axi_rready);
   assign wr_mapped = awaddr_q == REG_ACC_OFS || awaddr_q == REG_FLAGS_OFS ||
                      awaddr_q == REG_LPTR_OFS || awaddr_q == REG_LHIGH_OFS ||
                      awaddr_q == REG_SKIPS_OFS;

   // write path: address and data taken in either order
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (aw_hs) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         bvalid_q  <= bvalid_d;
         awready_q <= ~aw_have_d & ~bvalid_d;
         wready_q  <= ~w_have_d & ~bvalid_d;
      end
   end

   // read word select
   always_comb begin
      rd_word   = 32'h0000_0000;
      rd_mapped = 1'b1;
      case (s_axi_araddr)
         REG_ACC_OFS:   rd_word[7:0]       = acc_q;
         REG_FLAGS_OFS: rd_word[3:0]       = flags_q;
         REG_LPTR_OFS:  rd_word[7:0]       = lptr_q;
         REG_LHIGH_OFS: rd_word[ROM_W-9:0] = lhigh_q;
         REG_SKIPS_OFS: rd_word[7:0]       = skips_q;
         default:       rd_mapped          = 1'b0;
      endcase
   end

   // read path: one read under way at a time
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OKAY;
      end else begin
         if (ar_hs) begin
            rdata_q <= rd_word;
            rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         rvalid_q  <= rvalid_d;
         arready_q <= ~rvalid_d;
      end
   end

   // ----------------------------------------------------------------
   // issue stage and skip annulment
   // ----------------------------------------------------------------
   // the word fetched alongside a taken skip becomes the dummy cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ex_valid_q <= 1'b0;
         ex_q       <= '0;
         rom_addr_q <= '0;
      end else begin
         ex_valid_q <= instr_valid & ~taken;
         if (instr_valid) begin
            ex_q       <= instr;
            rom_addr_q <= {(instr.op == OP_TRDL) ? LAST_PAGE : instr.page, lptr_q};
         end
      end
   end

   // ----------------------------------------------------------------
   // architectural registers
   // ----------------------------------------------------------------
   // accumulator: execution wins over a bus write in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc_q <= ACC_RST;
      end else if (wr_acc) begin
         acc_q <= acc_n;
      end else if (reg_wr && awaddr_q == REG_ACC_OFS) begin
         acc_q <= wdata_q[7:0];
      end
   end

   // status flags
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags_q <= FLAGS_RST;
      end else if (ex_valid_q) begin
         flags_q <= flags_n;
      end else if (reg_wr && awaddr_q == REG_FLAGS_OFS) begin
         flags_q <= wdata_q[3:0];
      end
   end

   // table pointer and high-byte latch
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lptr_q  <= LPTR_RST;
         lhigh_q <= '0;
      end else begin
         if (reg_wr && awaddr_q == REG_LPTR_OFS) begin
            lptr_q <= wdata_q[7:0];
         end
         if (wr_lh) begin
            lhigh_q <= rom_rdata[ROM_W-1:8];
         end
      end
   end

   // memory write-back, skip pulse and taken-skip count
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mem_we_q    <= 1'b0;
         mem_waddr_q <= 8'h00;
         mem_wdata_q <= 8'h00;
         skip_q      <= 1'b0;
         done_q      <= 1'b0;
         skips_q     <= SKIPS_RST;
      end else begin
         mem_we_q    <= wr_mem;
         mem_waddr_q <= ex_q.addr;
         mem_wdata_q <= wd;
         skip_q      <= taken;
         done_q      <= ex_valid_q;
         if (taken) begin
            skips_q <= skips_q + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign mem_raddr         = ex_q.addr;
   assign mem_we            = mem_we_q;
   assign mem_waddr         = mem_waddr_q;
   assign mem_wdata         = mem_wdata_q;
   assign rom_addr          = rom_addr_q;
   assign acc               = acc_q;
   assign flags             = flags_q;
   assign lookup_high_latch = lhigh_q;
   assign skip              = skip_q;
   assign done              = done_q;
   assign s_axi_awready     = awready_q;
   assign s_axi_wready      = wready_q;
   assign s_axi_bvalid      = bvalid_q;
   assign s_axi_bresp       = bresp_q;
   assign s_axi_arready     = arready_q;
   assign s_axi_rvalid      = rvalid_q;
   assign s_axi_rdata       = rdata_q;
   assign s_axi_rresp       = rresp_q;

endmodule : medt_exec
